// ---- rtl/pwm_step_gen.v ----
`timescale 1ns/1ps
`include "rx_gpio_regs.vh"

// PWM generator: a fractional divider makes the base-rate enable from the
// system clock, a prescaler divides it by one plus the frequency field,
// and a 255-step counter compares against the duty value.
module pwm_step_gen (
	// Clock and reset.
	input wire clk_sys_i,
	input wire rst_n_i,
	// Settings.
	input wire enable_i,
	input wire [5:0] freq_i,
	input wire [7:0] duty_i,
	// Waveform.
	output reg pwm_o
);

	// Base-rate enable is made by adding the base rate each cycle, in MHz.
	// Worked out as integers, then cut to the accumulator width on purpose.
	localparam integer ACC_INC_I = `PWM_BASE_KHZ / 1000;
	localparam integer ACC_MOD_I = `SYS_CLK_KHZ / 1000;
	localparam [5:0] ACC_INC = ACC_INC_I[5:0];
	localparam [5:0] ACC_MOD = ACC_MOD_I[5:0];

	reg [5:0] acc_q;
	reg [5:0] pre_q;
	reg [7:0] step_q;
	wire [5:0] acc_sum;
	wire base_tick;

	assign acc_sum = acc_q + ACC_INC;
	assign base_tick = (acc_sum >= ACC_MOD);

	// The base tick carries some jitter of one system cycle; only the
	// average rate is exact, which is what the repetition rate needs.
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc_q <= 6'h00;
			pre_q <= 6'h00;
			step_q <= 8'h00;
			pwm_o <= 1'b0;
		end else if (!enable_i) begin
			acc_q <= 6'h00;
			pre_q <= 6'h00;
			step_q <= 8'h00;
			pwm_o <= 1'b0;
		end else begin
			acc_q <= base_tick ? (acc_sum - ACC_MOD) : acc_sum;
			if (base_tick) begin
				if (pre_q == freq_i) begin
					pre_q <= 6'h00;
					step_q <= (step_q == `PWM_LAST_STEP) ? 8'h00 : step_q + 8'h01;
				end else begin
					pre_q <= pre_q + 6'h01;
				end
			end
			pwm_o <= (step_q < duty_i);
		end
	end

endmodule // pwm_step_gen

// ---- rtl/receiver_gpio_pwm_control.v ----
`timescale 1ns/1ps
`include "rx_gpio_regs.vh"

module receiver_gpio_pwm_control (
	// Clock and reset.
	input wire clk_sys_i,
	input wire rst_n_i,
	// Serial slave selection.
	input wire ssel_i,
	output reg spi_port_en_o,
	output reg twowire_port_en_o,
	// Local register port, fed by the serial slave decoder.
	input wire [6:0] loc_addr_i,
	input wire [7:0] loc_wdata_i,
	input wire loc_wr_i,
	input wire loc_rd_i,
	output reg [7:0] loc_rdata_o,
	output reg loc_rvalid_o,
	// Control channel writes from the transmitter unit.
	input wire [6:0] ctl_addr_i,
	input wire [7:0] ctl_wdata_i,
	input wire ctl_wr_i,
	// Configuration EEPROM load.
	input wire [6:0] ee_addr_i,
	input wire [7:0] ee_wdata_i,
	input wire ee_wr_i,
	// Link and remote execution state.
	input wire link_up_i,
	input wire exec_done_i,
	input wire exec_ok_i,
	// Alternative sources for outputs 2:0.
	input wire tx_mirror_en_i,
	input wire [2:0] transmitter_direct_inputs_i,
	input wire master_en_active_i,
	input wire [2:0] master_en_i,
	// General purpose pins.
	input wire [3:0] general_inputs_i,
	output reg [3:0] general_outputs_o,
	output reg [3:0] general_outputs_oe_o,
	output reg [1:0] high_drive_o,
	output reg wake_o,
	// Input levels as seen by the transmitter unit.
	output reg [7:0] remote_input_levels_o
);

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------

	// True when a write strobe hits one register address.
	function hit;
		input we;
		input [6:0] addr;
		input [6:0] reg_addr;
		begin
			hit = we && (addr == reg_addr);
		end
	endfunction

	// Forces the must-be-zero bits of the output control register low.
	function [7:0] pio_clean;
		input [7:0] d;
		begin
			pio_clean = d & `PIO_WRITE_MASK;
		end
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	reg gpio_mode_q;
	reg exec_ok_q;
	reg [3:0] in_lvl_q;
	reg [7:0] pio_q;
	reg [7:0] pwme_q;
	reg [7:0] pwmd_q;
	reg [7:0] pio_act_q;
	reg [7:0] pwme_act_q;
	reg [7:0] pwmd_act_q;
	reg [7:0] wake_q;
	reg [7:0] irq_q;

	wire loc_open;
	wire loc_we;
	wire commit_stb;
	wire in_change;
	wire pwm_on;
	wire pwm_wave;
	reg [7:0] irq_d;
	reg [3:0] out_d;
	reg [7:0] rd_mux;

	// The serial slave port exists only while the unit is not in GPIO
	// mode, so local accesses are ignored once the pins are repurposed.
	assign loc_open = ~gpio_mode_q;
	assign loc_we = loc_wr_i & loc_open;

	// A commit is the value one written by the control channel.
	assign commit_stb = hit(ctl_wr_i, ctl_addr_i, `REMOTE_COMMIT_TRIGGER_ADDR) &&
		(ctl_wdata_i == `COMMIT_VALUE);

	assign in_change = gpio_mode_q && (general_inputs_i != in_lvl_q);

	assign pwm_on = (pwme_act_q[`PWM_MODE_MSB:`PWM_MODE_LSB] == `PWM_MODE_ON);

	// ------------------------------------------------------------------
	// PWM generator
	// ------------------------------------------------------------------
	pwm_step_gen pwm_step_gen_inst (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.enable_i(pwm_on),
		.freq_i(pwme_act_q[`PWM_FREQ_MSB:0]),
		.duty_i(pwmd_act_q),
		.pwm_o(pwm_wave)
	);

	// ------------------------------------------------------------------
	// Status register
	// ------------------------------------------------------------------

	// The mode bit is written by the EEPROM load or the local port only;
	// a control channel write to the status address changes nothing.
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gpio_mode_q <= 1'b0;
			exec_ok_q <= 1'b0;
		end else begin
			if (hit(ee_wr_i, ee_addr_i, `RECEIVER_UNIT_STATUS_ADDR)) begin
				gpio_mode_q <= ee_wdata_i[`STA_GPIO_MODE_BIT];
			end else if (hit(loc_we, loc_addr_i, `RECEIVER_UNIT_STATUS_ADDR)) begin
				gpio_mode_q <= loc_wdata_i[`STA_GPIO_MODE_BIT];
			end
			if (exec_done_i) begin
				exec_ok_q <= exec_ok_i;
			end
		end
	end

	// ------------------------------------------------------------------
	// Remote input levels
	// ------------------------------------------------------------------

	// In GPIO mode the pins are sampled every cycle; in serial mode the
	// pins are disconnected and a local MCU may emulate the levels.
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			in_lvl_q <= `NIBBLE_RESET;
		end else if (gpio_mode_q) begin
			in_lvl_q <= general_inputs_i;
		end else if (hit(loc_we, loc_addr_i, `REMOTE_INPUT_LEVELS_ADDR)) begin
			in_lvl_q <= loc_wdata_i[3:0];
		end
	end

	// ------------------------------------------------------------------
	// Output, PWM and wake registers
	// ------------------------------------------------------------------

	// The EEPROM load reaches these registers at any mode, the control
	// channel all but the wake register, the local port only outside GPIO
	// mode. The EEPROM load wins over the control channel, which wins over
	// the local port; the two software sides are expected not to fight over one register.
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pio_q <= `REG8_RESET;
			pwme_q <= `REG8_RESET;
			pwmd_q <= `REG8_RESET;
			wake_q <= `REG8_RESET;
		end else begin
			if (hit(ee_wr_i, ee_addr_i, `OUTPUT_PIN_CONTROL_ADDR)) begin
				pio_q <= pio_clean(ee_wdata_i);
			end else if (hit(ctl_wr_i, ctl_addr_i, `OUTPUT_PIN_CONTROL_ADDR)) begin
				pio_q <= pio_clean(ctl_wdata_i);
			end else if (hit(loc_we, loc_addr_i, `OUTPUT_PIN_CONTROL_ADDR)) begin
				pio_q <= pio_clean(loc_wdata_i);
			end
			if (hit(ee_wr_i, ee_addr_i, `PWM_ENABLE_FREQUENCY_ADDR)) begin
				pwme_q <= ee_wdata_i;
			end else if (hit(ctl_wr_i, ctl_addr_i, `PWM_ENABLE_FREQUENCY_ADDR)) begin
				pwme_q <= ctl_wdata_i;
			end else if (hit(loc_we, loc_addr_i, `PWM_ENABLE_FREQUENCY_ADDR)) begin
				pwme_q <= loc_wdata_i;
			end
			if (hit(ee_wr_i, ee_addr_i, `PWM_DUTY_CYCLE_ADDR)) begin
				pwmd_q <= ee_wdata_i;
			end else if (hit(ctl_wr_i, ctl_addr_i, `PWM_DUTY_CYCLE_ADDR)) begin
				pwmd_q <= ctl_wdata_i;
			end else if (hit(loc_we, loc_addr_i, `PWM_DUTY_CYCLE_ADDR)) begin
				pwmd_q <= loc_wdata_i;
			end
			if (hit(ee_wr_i, ee_addr_i, `WAKE_CONFIG_ADDR)) begin
				wake_q <= ee_wdata_i;
			end else if (hit(loc_we, loc_addr_i, `WAKE_CONFIG_ADDR)) begin
				wake_q <= loc_wdata_i;
			end
		end
	end

	// ------------------------------------------------------------------
	// Applied copies
	// ------------------------------------------------------------------

	// Values written over the control channel stay pending until the
	// commit; values written on the receiver side apply at once outside a commit cycle.
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pio_act_q <= `REG8_RESET;
			pwme_act_q <= `REG8_RESET;
			pwmd_act_q <= `REG8_RESET;
		end else if (commit_stb) begin
			pio_act_q <= pio_q;
			pwme_act_q <= pwme_q;
			pwmd_act_q <= pwmd_q;
		end else begin
			if (hit(ee_wr_i, ee_addr_i, `OUTPUT_PIN_CONTROL_ADDR)) begin
				pio_act_q <= pio_clean(ee_wdata_i);
			end else if (hit(loc_we, loc_addr_i, `OUTPUT_PIN_CONTROL_ADDR)) begin
				pio_act_q <= pio_clean(loc_wdata_i);
			end
			if (hit(ee_wr_i, ee_addr_i, `PWM_ENABLE_FREQUENCY_ADDR)) begin
				pwme_act_q <= ee_wdata_i;
			end else if (hit(loc_we, loc_addr_i, `PWM_ENABLE_FREQUENCY_ADDR)) begin
				pwme_act_q <= loc_wdata_i;
			end
			if (hit(ee_wr_i, ee_addr_i, `PWM_DUTY_CYCLE_ADDR)) begin
				pwmd_act_q <= ee_wdata_i;
			end else if (hit(loc_we, loc_addr_i, `PWM_DUTY_CYCLE_ADDR)) begin
				pwmd_act_q <= loc_wdata_i;
			end
		end
	end

	// ------------------------------------------------------------------
	// Local interrupt flags
	// ------------------------------------------------------------------

	// Flags live only here and never travel to the transmitter. Software
	// clears with ones, but a new event in the same cycle stays set.
	always @* begin
		irq_d = irq_q;
		if (hit(loc_we, loc_addr_i, `INTERRUPT_FLAGS_ADDR)) begin
			irq_d = irq_d & ~loc_wdata_i;
		end
		if (in_change) begin
			irq_d[`IRQ_INPUT_CHANGE_BIT] = 1'b1;
		end
		if (commit_stb) begin
			irq_d[`IRQ_COMMIT_BIT] = 1'b1;
		end
		irq_d = irq_d & `IRQ_USED_MASK;
	end

	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_q <= `REG8_RESET;
		end else begin
			irq_q <= irq_d;
		end
	end

	// ------------------------------------------------------------------
	// Output pin selection
	// ------------------------------------------------------------------

	// Master bus enables take precedence over the mirror of the
	// transmitter inputs, which takes precedence over plain data.
	always @* begin
		out_d = pio_act_q[3:0];
		if (master_en_active_i) begin
			out_d[2:0] = master_en_i;
		end else if (tx_mirror_en_i) begin
			out_d[2:0] = transmitter_direct_inputs_i;
		end
		if (pwm_on) begin
			out_d[3] = pwm_wave;
		end
		if (!link_up_i) begin
			out_d = `NIBBLE_RESET;
		end
	end

	// Pins are driven only in GPIO mode; in serial mode they belong to
	// the slave port and the registers are cut off from them.
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			general_outputs_o <= `NIBBLE_RESET;
			general_outputs_oe_o <= `NIBBLE_RESET;
			high_drive_o <= 2'h0;
			wake_o <= 1'b0;
			spi_port_en_o <= 1'b0;
			twowire_port_en_o <= 1'b0;
			remote_input_levels_o <= `REG8_RESET;
		end else begin
			general_outputs_o <= gpio_mode_q ? out_d : `NIBBLE_RESET;
			general_outputs_oe_o <= {4{gpio_mode_q}};
			high_drive_o <= (gpio_mode_q && link_up_i) ?
				{pio_act_q[`PIO_HD3_BIT], pio_act_q[`PIO_HD1_BIT]} : 2'h0;
			wake_o <= gpio_mode_q && |(wake_q[3:2] & in_lvl_q[3:2]);
			spi_port_en_o <= ~gpio_mode_q & ~ssel_i;
			twowire_port_en_o <= ~gpio_mode_q & ssel_i;
			remote_input_levels_o <= {4'h0, in_lvl_q};
		end
	end

	// ------------------------------------------------------------------
	// Local read port
	// ------------------------------------------------------------------

	// Only receiver registers decode; anything else, transmitter-side
	// addresses included, reads as zero.
	always @* begin
		case (loc_addr_i)
			`RECEIVER_UNIT_STATUS_ADDR: rd_mux = {exec_ok_q, gpio_mode_q, 6'h00};
			`REMOTE_INPUT_LEVELS_ADDR: rd_mux = {4'h0, in_lvl_q};
			`OUTPUT_PIN_CONTROL_ADDR: rd_mux = pio_q;
			`PWM_ENABLE_FREQUENCY_ADDR: rd_mux = pwme_q;
			`PWM_DUTY_CYCLE_ADDR: rd_mux = pwmd_q;
			`WAKE_CONFIG_ADDR: rd_mux = wake_q;
			`INTERRUPT_FLAGS_ADDR: rd_mux = irq_q;
			default: rd_mux = 8'h00;
		endcase
	end

	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			loc_rdata_o <= 8'h00;
			loc_rvalid_o <= 1'b0;
		end else begin
			loc_rvalid_o <= loc_rd_i & loc_open;
			loc_rdata_o <= (loc_rd_i & loc_open) ? rd_mux : 8'h00;
		end
	end

endmodule // receiver_gpio_pwm_control

// ---- rtl/rx_gpio_regs.vh ----
`ifndef RX_GPIO_REGS_VH
`define RX_GPIO_REGS_VH

// ----------------------------------------------------------------------
// Register offsets of the receiver unit (7-bit register address space).
// ----------------------------------------------------------------------
`define RECEIVER_UNIT_STATUS_ADDR 7'h06
`define REMOTE_INPUT_LEVELS_ADDR 7'h07
`define OUTPUT_PIN_CONTROL_ADDR 7'h41
`define PWM_ENABLE_FREQUENCY_ADDR 7'h42
`define PWM_DUTY_CYCLE_ADDR 7'h43
`define REMOTE_COMMIT_TRIGGER_ADDR 7'h44
`define WAKE_CONFIG_ADDR 7'h45
`define INTERRUPT_FLAGS_ADDR 7'h46

// ----------------------------------------------------------------------
// Field positions and values.
// ----------------------------------------------------------------------
`define STA_EXEC_OK_BIT 7
`define STA_GPIO_MODE_BIT 6
`define PIO_HD3_BIT 7
`define PIO_HD1_BIT 5
`define PIO_WRITE_MASK 8'hAF
`define PWM_MODE_MSB 7
`define PWM_MODE_LSB 6
`define PWM_MODE_ON 2'h3
`define PWM_FREQ_MSB 5
`define COMMIT_VALUE 8'h01
`define IRQ_INPUT_CHANGE_BIT 0
`define IRQ_COMMIT_BIT 1
`define IRQ_USED_MASK 8'h03

// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define REG8_RESET 8'h00
`define NIBBLE_RESET 4'h0

// ----------------------------------------------------------------------
// Timing: PWM base rate, system rate and the last step of one period.
// ----------------------------------------------------------------------
`define PWM_BASE_KHZ 16000
`define SYS_CLK_KHZ 20000
`define PWM_LAST_STEP 8'hFE

`endif

// ---- test/ctl_link_model.sv ----
`timescale 1ns/1ps

// Transmitter side: control channel writes, link state, execute results.
module ctl_link_model (
	// Clock.
	input wire clk_sys_i,
	// Control channel.
	output logic [6:0] ctl_addr_o = 7'h00,
	output logic [7:0] ctl_wdata_o = 8'h00,
	output logic ctl_wr_o = 1'b0,
	// Link and execute state.
	output logic link_up_o = 1'b0,
	output logic exec_done_o = 1'b0,
	output logic exec_ok_o = 1'b0
);
	// One write per call, so both sides never race on a register.
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		ctl_addr_o = a;
		ctl_wdata_o = d;
		ctl_wr_o = 1'b1;
		@(negedge clk_sys_i);
		ctl_wr_o = 1'b0;
		ctl_addr_o = ~a; // A released bus must not look like the last write.
		ctl_wdata_o = ~d;
	endtask
	// The commit value applies the stored output and PWM settings.
	task automatic commit();
		wr(7'h44, 8'h01);
	endtask
	// Execute result is a one-cycle pulse with its outcome.
	task automatic exec(input logic ok);
		@(negedge clk_sys_i);
		exec_ok_o = ok;
		exec_done_o = 1'b1;
		@(negedge clk_sys_i);
		exec_done_o = 1'b0;
	endtask
	task automatic link(input logic up);
		@(negedge clk_sys_i);
		link_up_o = up;
	endtask
endmodule // ctl_link_model

// ---- test/receiver_gpio_pwm_control_props.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Port-level checker for the receiver pin and PWM control block.
// ----------------------------------------------------------------------
module receiver_gpio_pwm_control_props (
	// Clock and reset.
	input wire clk_sys_i,
	input wire rst_n_i,
	// Port selection and local reads.
	input wire ssel_i,
	input wire spi_port_en_o,
	input wire twowire_port_en_o,
	input wire loc_rd_i,
	input wire [7:0] loc_rdata_o,
	input wire loc_rvalid_o,
	// Link and pins.
	input wire link_up_i,
	input wire master_en_active_i,
	input wire [2:0] master_en_i,
	input wire [3:0] general_outputs_o,
	input wire [3:0] general_outputs_oe_o,
	input wire [1:0] high_drive_o,
	input wire [7:0] remote_input_levels_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	// Serial mode is visible as either slave port being enabled.
	wire serial_w = spi_port_en_o | twowire_port_en_o;

	// Two low samples are needed because the pins are registered once.
	sequence s_link_down;
		!link_up_i ##1 !link_up_i;
	endsequence
	sequence s_master_gpio;
		master_en_active_i && link_up_i && general_outputs_oe_o == 4'hF;
	endsequence

	chk_oe_uniform: assert property (general_outputs_oe_o == 4'h0 || general_outputs_oe_o == 4'hF)
		else $error("output enables split");
	chk_serial_no_pins: assert property (serial_w |-> general_outputs_oe_o == 4'h0 && !(spi_port_en_o && twowire_port_en_o))
		else $error("pins driven in serial mode");
	chk_port_select: assert property (serial_w |-> twowire_port_en_o == $past(ssel_i))
		else $error("slave port does not follow select");
	chk_link_gate: assert property (s_link_down |-> general_outputs_o == 4'h0 && high_drive_o == 2'h0)
		else $error("outputs active without link");
	chk_rvalid_cause: assert property (loc_rvalid_o |-> $past(loc_rd_i))
		else $error("read data without read");
	chk_rdata_idle: assert property (!loc_rvalid_o |-> loc_rdata_o == 8'h00)
		else $error("read data not zero when idle");
	chk_read_answer: assert property (loc_rd_i && serial_w |=> loc_rvalid_o)
		else $error("local read not answered");
	chk_levels_rsvd: assert property (remote_input_levels_o[7:4] == 4'h0)
		else $error("reserved input bits set");
	chk_master_pins: assert property (s_master_gpio ##1 s_master_gpio |-> general_outputs_o[2:0] == $past(master_en_i))
		else $error("master enables not on outputs");
endmodule // receiver_gpio_pwm_control_props

bind receiver_gpio_pwm_control receiver_gpio_pwm_control_props receiver_gpio_pwm_control_props_inst (
	.clk_sys_i(clk_sys_i),
	.rst_n_i(rst_n_i),
	.ssel_i(ssel_i),
	.spi_port_en_o(spi_port_en_o),
	.twowire_port_en_o(twowire_port_en_o),
	.loc_rd_i(loc_rd_i),
	.loc_rdata_o(loc_rdata_o),
	.loc_rvalid_o(loc_rvalid_o),
	.link_up_i(link_up_i),
	.master_en_active_i(master_en_active_i),
	.master_en_i(master_en_i),
	.general_outputs_o(general_outputs_o),
	.general_outputs_oe_o(general_outputs_oe_o),
	.high_drive_o(high_drive_o),
	.remote_input_levels_o(remote_input_levels_o)
);

// ---- test/test_receiver_gpio_pwm_control.sv ----
`timescale 1ns/1ps

// Compare two values and count the outcome.
`define CHK(g, e) begin \
	checked++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("[ERR] %0t got %0h expected %0h", $time, g, e); \
	end \
end

module test_receiver_gpio_pwm_control;
	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic ssel_i = 1'b0;
	logic [6:0] loc_addr_i = 7'h00;
	logic [7:0] loc_wdata_i = 8'h00;
	logic loc_wr_i = 1'b0;
	logic loc_rd_i = 1'b0;
	logic [6:0] ee_addr_i = 7'h00;
	logic [7:0] ee_wdata_i = 8'h00;
	logic ee_wr_i = 1'b0;
	logic tx_mirror_en_i = 1'b0;
	logic [2:0] transmitter_direct_inputs_i = 3'h0;
	logic master_en_active_i = 1'b0;
	logic [2:0] master_en_i = 3'h0;
	logic [3:0] general_inputs_i = 4'h0;
	wire [6:0] ctl_addr_i;
	wire [7:0] ctl_wdata_i, loc_rdata_o, remote_input_levels_o;
	wire ctl_wr_i, link_up_i, exec_done_i, exec_ok_i;
	wire loc_rvalid_o, spi_port_en_o, twowire_port_en_o, wake_o;
	wire [3:0] general_outputs_o, general_outputs_oe_o;
	wire [1:0] high_drive_o;
	int error_cnt = 0;
	int checked = 0;
	int cycles = 0;
	int hi, ri;

	receiver_gpio_pwm_control receiver_gpio_pwm_control_inst (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.ssel_i(ssel_i),
		.spi_port_en_o(spi_port_en_o),
		.twowire_port_en_o(twowire_port_en_o),
		.loc_addr_i(loc_addr_i),
		.loc_wdata_i(loc_wdata_i),
		.loc_wr_i(loc_wr_i),
		.loc_rd_i(loc_rd_i),
		.loc_rdata_o(loc_rdata_o),
		.loc_rvalid_o(loc_rvalid_o),
		.ctl_addr_i(ctl_addr_i),
		.ctl_wdata_i(ctl_wdata_i),
		.ctl_wr_i(ctl_wr_i),
		.ee_addr_i(ee_addr_i),
		.ee_wdata_i(ee_wdata_i),
		.ee_wr_i(ee_wr_i),
		.link_up_i(link_up_i),
		.exec_done_i(exec_done_i),
		.exec_ok_i(exec_ok_i),
		.tx_mirror_en_i(tx_mirror_en_i),
		.transmitter_direct_inputs_i(transmitter_direct_inputs_i),
		.master_en_active_i(master_en_active_i),
		.master_en_i(master_en_i),
		.general_inputs_i(general_inputs_i),
		.general_outputs_o(general_outputs_o),
		.general_outputs_oe_o(general_outputs_oe_o),
		.high_drive_o(high_drive_o),
		.wake_o(wake_o),
		.remote_input_levels_o(remote_input_levels_o)
	);
	ctl_link_model ctl_link_model_inst (
		.clk_sys_i(clk_sys_i),
		.ctl_addr_o(ctl_addr_i),
		.ctl_wdata_o(ctl_wdata_i),
		.ctl_wr_o(ctl_wr_i),
		.link_up_o(link_up_i),
		.exec_done_o(exec_done_i),
		.exec_ok_o(exec_ok_i)
	);

	// 20 MHz system clock.
	always #25 clk_sys_i = ~clk_sys_i;

	// A hang counts as a mismatch; the tests need about 13600 cycles.
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 30000) begin
			error_cnt++;
			final_report();
		end
	end

	// ------------------------------------------------------------------
	// Drivers
	// ------------------------------------------------------------------
	task automatic nc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task automatic lw(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		loc_addr_i = a;
		loc_wdata_i = d;
		loc_wr_i = 1'b1;
		@(negedge clk_sys_i);
		loc_wr_i = 1'b0;
	endtask
	task automatic ew(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		ee_addr_i = a;
		ee_wdata_i = d;
		ee_wr_i = 1'b1;
		@(negedge clk_sys_i);
		ee_wr_i = 1'b0;
	endtask
	// The answer stands one cycle, so it is judged at the next falling edge.
	task automatic lr(input logic [6:0] a, input logic v, input logic [7:0] d);
		@(negedge clk_sys_i);
		loc_addr_i = a;
		loc_rd_i = 1'b1;
		@(negedge clk_sys_i);
		loc_rd_i = 1'b0;
		`CHK(loc_rvalid_o, v)
		`CHK(loc_rdata_o, d)
	endtask
	// Counts high cycles and rising edges of output 3 over 2550 cycles.
	task automatic measure();
		logic prev;
		hi = 0;
		ri = 0;
		prev = general_outputs_o[3];
		repeat (2550) begin
			@(negedge clk_sys_i);
			hi += general_outputs_o[3];
			ri += (general_outputs_o[3] && !prev);
			prev = general_outputs_o[3];
		end
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_serial();
		nc(2);
		`CHK({spi_port_en_o, twowire_port_en_o}, 2'b10)
		ssel_i = 1'b1;
		nc(2);
		`CHK({spi_port_en_o, twowire_port_en_o}, 2'b01)
		lr(7'h06, 1'b1, 8'h00);
		lw(7'h41, 8'hFF);
		lr(7'h41, 1'b1, 8'hAF);
		lw(7'h42, 8'hC5);
		lr(7'h42, 1'b1, 8'hC5);
		lw(7'h42, 8'h00);
		lw(7'h43, 8'h3C);
		lr(7'h43, 1'b1, 8'h3C);
		lr(7'h30, 1'b1, 8'h00);
		// A commit marks the local flag copy; ones written clear it again.
		ctl_link_model_inst.commit();
		lr(7'h46, 1'b1, 8'h02);
		lw(7'h46, 8'hFF);
		lr(7'h46, 1'b1, 8'h00);
		lw(7'h07, 8'h0A);
		nc(2);
		`CHK(remote_input_levels_o, 8'h0A)
		ctl_link_model_inst.wr(7'h06, 8'h40);
		lr(7'h06, 1'b1, 8'h00);
		ctl_link_model_inst.exec(1'b1);
		lr(7'h06, 1'b1, 8'h80);
		ctl_link_model_inst.exec(1'b0);
		lr(7'h06, 1'b1, 8'h00);
	endtask

	task automatic t_gpio();
		ew(7'h06, 8'h40);
		nc(3);
		`CHK({spi_port_en_o, twowire_port_en_o, general_outputs_oe_o}, 6'h0F)
		lr(7'h06, 1'b0, 8'h00);
		ew(7'h41, 8'h05);
		nc(3);
		`CHK(general_outputs_o, 4'h0)
		ctl_link_model_inst.link(1'b1);
		nc(3);
		`CHK(general_outputs_o, 4'h5)
		ctl_link_model_inst.wr(7'h41, 8'h0A);
		ctl_link_model_inst.wr(7'h44, 8'h02);
		nc(3);
		`CHK(general_outputs_o, 4'h5)
		ctl_link_model_inst.commit();
		nc(3);
		`CHK(general_outputs_o, 4'hA)
		ctl_link_model_inst.wr(7'h41, 8'hA0);
		ctl_link_model_inst.commit();
		nc(3);
		`CHK({high_drive_o, general_outputs_o}, 6'h30)
		ctl_link_model_inst.link(1'b0);
		nc(3);
		`CHK({high_drive_o, general_outputs_o}, 6'h00)
		ctl_link_model_inst.link(1'b1);
	endtask

	task automatic t_pins();
		general_inputs_i = 4'h9;
		nc(4);
		`CHK(remote_input_levels_o, 8'h09)
		ew(7'h45, 8'h0C);
		general_inputs_i = 4'h4;
		nc(4);
		`CHK(wake_o, 1'b1)
		general_inputs_i = 4'h3;
		nc(4);
		`CHK(wake_o, 1'b0)
		tx_mirror_en_i = 1'b1;
		transmitter_direct_inputs_i = 3'h5;
		nc(3);
		`CHK(general_outputs_o[2:0], 3'h5)
		master_en_active_i = 1'b1;
		master_en_i = 3'h2;
		nc(3);
		`CHK(general_outputs_o[2:0], 3'h2)
		tx_mirror_en_i = 1'b0;
		master_en_active_i = 1'b0;
	endtask

	task automatic t_pwm();
		ctl_link_model_inst.wr(7'h41, 8'h08);
		ctl_link_model_inst.wr(7'h42, 8'hC0);
		ctl_link_model_inst.wr(7'h43, 8'h80);
		ctl_link_model_inst.commit();
		nc(4);
		measure();
		`CHK(hi inside {[1240:1320]}, 1'b1)
		`CHK(ri inside {[7:9]}, 1'b1)
		ctl_link_model_inst.wr(7'h42, 8'hC1);
		ctl_link_model_inst.commit();
		nc(4);
		measure();
		`CHK(ri inside {[3:5]}, 1'b1)
		ctl_link_model_inst.wr(7'h43, 8'hFF);
		ctl_link_model_inst.commit();
		nc(700);
		measure();
		`CHK(hi, 2550)
		ctl_link_model_inst.wr(7'h41, 8'h00);
		ctl_link_model_inst.wr(7'h42, 8'h80);
		ctl_link_model_inst.commit();
		nc(4);
		measure();
		`CHK(hi, 0)
		ctl_link_model_inst.wr(7'h41, 8'h08);
		ctl_link_model_inst.wr(7'h42, 8'h00);
		ctl_link_model_inst.commit();
		nc(4);
		measure();
		`CHK(hi, 2550)
	endtask

	// Prints the counts, then the verdict, and ends the run.
	task automatic final_report();
		$display("Checks %0d, errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		nc(10);
		rst_n_i = 1'b1;
		t_serial();
		t_gpio();
		t_pins();
		t_pwm();
		final_report();
	end
endmodule // test_receiver_gpio_pwm_control
